// ---- hw/bsp_pkg.sv ----
// Purpose: Shared constants and types for the buffered serial port core.
// Assumes: 32-bit register word, register offsets are byte addresses.
// Notes: Element length codes map to 8/12/16/20/24/32 bits.
package bsp_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_RX_DATA = 5'h00;
  localparam logic [4:0] OFS_TX_DATA = 5'h04;
  localparam logic [4:0] OFS_CONTROL = 5'h08;
  localparam logic [4:0] OFS_PIN_CFG = 5'h0C;
  localparam logic [4:0] OFS_CONFIG = 5'h10;

  // ----------------------------------------
  // Control register bit positions
  // ----------------------------------------
  localparam int CTL_RX_RST = 0;
  localparam int CTL_RX_RDY = 1;
  localparam int CTL_RX_OVR = 2;
  localparam int CTL_RX_SERR = 3;
  localparam int CTL_TX_RST = 16;
  localparam int CTL_TX_RDY = 17;
  localparam int CTL_TX_UND = 18;
  localparam int CTL_TX_SERR = 19;
  localparam int CTL_GEN_RST = 22;
  localparam int CTL_FRM_RST = 23;

  // ----------------------------------------
  // Pin and format configuration layouts
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] gpio_out;          // tx fs, rx fs, tx clk, rx clk
    logic ext_clk_sel;
    logic tx_sync_polarity;
    logic rx_sync_polarity;
    logic tx_sync_dir_sel;
    logic rx_sync_dir_sel;
    logic tx_clock_dir_sel;
    logic rx_clock_dir_sel;
  } bsp_pin_cfg_t;

  typedef struct packed {
    logic [7:0] frame_period;      // Bit clocks per frame minus one
    logic [7:0] clk_div;           // Half period of generated clock minus one
    logic [2:0] tx_len_code;
    logic [2:0] rx_len_code;
  } bsp_cfg_t;

  localparam bsp_pin_cfg_t PIN_CFG_RST = '0;
  localparam bsp_cfg_t CONFIG_RST = '{frame_period: 8'h1F, clk_div: 8'h01,
                                      tx_len_code: 3'h2, rx_len_code: 3'h2};

  // Transmit sequencer, Gray coded along idle, armed, shift
  typedef enum logic [1:0] {
    BSP_TX_IDLE = 2'b00,
    BSP_TX_ARMED = 2'b01,
    BSP_TX_SHIFT = 2'b11
  } bsp_tx_state_t;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [5:0] bsp_elem_len(input logic [2:0] code);
    case (code)
      3'h0: bsp_elem_len = 6'h08;
      3'h1: bsp_elem_len = 6'h0C;
      3'h2: bsp_elem_len = 6'h10;
      3'h3: bsp_elem_len = 6'h14;
      3'h4: bsp_elem_len = 6'h18;
      default: bsp_elem_len = 6'h20;
    endcase
  endfunction

  function automatic logic [31:0] bsp_left_align(input logic [31:0] data,
                                                 input logic [5:0] len);
    bsp_left_align = data << (6'h20 - len);
  endfunction

endpackage

// ---- hw/bsp_core.sv ----
// Purpose: Data path and reset control of a full-duplex buffered serial port.
// Assumes: Serial pins are asynchronous to sys_clk and much slower than it.
// Notes: Receive is triple buffered, transmit double buffered.
// Function
// - Completed receive element moves to holding buffer only if that is empty or empties in the same cycle.
// - Holding buffer moves to receive data register only after previous value read.
// - Transmit data loads empty shift register at once, else after last bit.
// - Transmit shifting starts only after a transmit frame sync.
// - Device reset clears all section reset bits, port stays in reset.
// - Separate bits reset receiver, transmitter and rate generator.
// - Serial output is high impedance in device or transmitter reset.
// - In section reset, clock pin direction follows select; output carries generated clock.
// - Frame sync output in section reset sits inactive, equal to polarity bit.
// - Section reset clears state, counters and all status flags.
// - With all reset bits zero, pins act as general purpose I/O.
// - Rate generator reset drives generated clock and frame sync low.
// - Frame sync output stays inactive while its own section is reset.
// - Transmitter ignores first frame sync after reset, shifts at second.
// - Control registers are written with whole 32-bit words only.
// - Processor reaches all registers; DMA reaches only data registers.
// - Receive and transmit run at once with independent clock and sync.
// - Receive ready sets on new data, clears on read or reset.
// - Transmit ready rises leaving reset and on each load, clears on write.
module bsp_core (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic dma_wr,
  input wire logic [31:0] dma_wdata,
  input wire logic dma_rd,
  output logic [31:0] dma_rdata,
  output logic rx_event,
  output logic tx_event,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic ext_source_clock,
  input wire logic rx_bit_clock_in,
  output logic rx_bit_clock_out,
  output logic rx_bit_clock_oe,
  input wire logic tx_bit_clock_in,
  output logic tx_bit_clock_out,
  output logic tx_bit_clock_oe,
  input wire logic rx_frame_sync_in,
  output logic rx_frame_sync_out,
  output logic rx_frame_sync_oe,
  input wire logic tx_frame_sync_in,
  output logic tx_frame_sync_out,
  output logic tx_frame_sync_oe
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Index: 0 rx clk, 1 tx clk, 2 rx fs, 3 tx fs, 4 data in, 5 ext clock
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic [5:0] pin_prev;

  // Two flops, third stage only for edge finding
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
      pin_prev <= 6'h00;
    end else begin
      pin_meta <= {ext_source_clock, serial_in, tx_frame_sync_in, rx_frame_sync_in,
                   tx_bit_clock_in, rx_bit_clock_in};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic rx_section_reset_n;
  logic tx_section_reset_n;
  logic rate_gen_reset_n;
  logic frame_gen_reset_n;
  bsp_pkg::bsp_pin_cfg_t pin_cfg;
  bsp_pkg::bsp_cfg_t cfg;
  logic ctl_wr;

  assign ctl_wr = reg_wr && (reg_addr == bsp_pkg::OFS_CONTROL);

  // Whole-word writes only; no byte lanes exist on this port
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_section_reset_n <= 1'b0;
      tx_section_reset_n <= 1'b0;
      rate_gen_reset_n <= 1'b0;
      frame_gen_reset_n <= 1'b0;
      pin_cfg <= bsp_pkg::PIN_CFG_RST;
      cfg <= bsp_pkg::CONFIG_RST;
    end else begin
      if (ctl_wr) begin
        rx_section_reset_n <= reg_wdata[bsp_pkg::CTL_RX_RST];
        tx_section_reset_n <= reg_wdata[bsp_pkg::CTL_TX_RST];
        rate_gen_reset_n <= reg_wdata[bsp_pkg::CTL_GEN_RST];
        frame_gen_reset_n <= reg_wdata[bsp_pkg::CTL_FRM_RST];
      end
      if (reg_wr && (reg_addr == bsp_pkg::OFS_PIN_CFG)) begin
        pin_cfg <= bsp_pkg::bsp_pin_cfg_t'(reg_wdata[10:0]);
      end
      if (reg_wr && (reg_addr == bsp_pkg::OFS_CONFIG)) begin
        cfg <= bsp_pkg::bsp_cfg_t'(reg_wdata[21:0]);
      end
    end
  end

  // ----------------------------------------
  // Sample rate generator
  // ----------------------------------------
  logic [7:0] div_cnt;
  logic [7:0] frm_cnt;
  logic generated_bit_clock;
  logic generated_frame_sync;
  logic src_tick;
  logic div_wrap;
  logic gen_rise;
  logic gen_fall;

  assign src_tick = pin_cfg.ext_clk_sel ? (pin_sync[5] && !pin_prev[5]) : 1'b1;
  assign div_wrap = src_tick && (div_cnt == cfg.clk_div) && rate_gen_reset_n;
  assign gen_rise = div_wrap && !generated_bit_clock;
  assign gen_fall = div_wrap && generated_bit_clock;

  // Divider; held low while the generator is in reset
  always_ff @(posedge sys_clk) begin
    if (reset || !rate_gen_reset_n) begin
      div_cnt <= 8'h00;
      generated_bit_clock <= 1'b0;
    end else if (src_tick) begin
      if (div_wrap) begin
        div_cnt <= 8'h00;
        generated_bit_clock <= !generated_bit_clock;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // Frame sync generator, one bit clock wide at frame start
  always_ff @(posedge sys_clk) begin
    if (reset || !rate_gen_reset_n) begin
      frm_cnt <= 8'h00;
      generated_frame_sync <= 1'b0;
    end else if (gen_rise) begin
      if (!frame_gen_reset_n) begin
        frm_cnt <= 8'h00;
        generated_frame_sync <= 1'b0;
      end else begin
        generated_frame_sync <= (frm_cnt == 8'h00);
        frm_cnt <= (frm_cnt == cfg.frame_period) ? 8'h00 : frm_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Clock and frame selection per section
  // ----------------------------------------
  logic rx_rise;
  logic rx_fall;
  logic tx_rise;
  logic rx_fs_int;
  logic tx_fs_int;

  // Each section picks its own clock and sync source
  assign rx_rise = pin_cfg.rx_clock_dir_sel ? gen_rise : (pin_sync[0] && !pin_prev[0]);
  assign rx_fall = pin_cfg.rx_clock_dir_sel ? gen_fall : (!pin_sync[0] && pin_prev[0]);
  assign tx_rise = pin_cfg.tx_clock_dir_sel ? gen_rise : (pin_sync[1] && !pin_prev[1]);
  assign rx_fs_int = pin_cfg.rx_sync_dir_sel ? generated_frame_sync
                                             : (pin_sync[2] ^ pin_cfg.rx_sync_polarity);
  assign tx_fs_int = pin_cfg.tx_sync_dir_sel ? generated_frame_sync
                                             : (pin_sync[3] ^ pin_cfg.tx_sync_polarity);

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  logic gpio_mode;

  // All section resets low: pins belong to software
  assign gpio_mode = !(rx_section_reset_n || tx_section_reset_n ||
                       rate_gen_reset_n || frame_gen_reset_n);

  assign rx_bit_clock_oe = pin_cfg.rx_clock_dir_sel;
  assign tx_bit_clock_oe = pin_cfg.tx_clock_dir_sel;
  assign rx_bit_clock_out = gpio_mode ? pin_cfg.gpio_out[0] : generated_bit_clock;
  assign tx_bit_clock_out = gpio_mode ? pin_cfg.gpio_out[1] : generated_bit_clock;
  assign rx_frame_sync_oe = pin_cfg.rx_sync_dir_sel;
  assign tx_frame_sync_oe = pin_cfg.tx_sync_dir_sel;
  // Inactive level equals the polarity bit while the section is in reset
  assign rx_frame_sync_out = gpio_mode ? pin_cfg.gpio_out[2] :
    ((rx_section_reset_n && generated_frame_sync) ^ pin_cfg.rx_sync_polarity);
  assign tx_frame_sync_out = gpio_mode ? pin_cfg.gpio_out[3] :
    ((tx_section_reset_n && generated_frame_sync) ^ pin_cfg.tx_sync_polarity);

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  logic [31:0] rx_shift_reg;
  logic [31:0] rx_holding_buffer;
  logic [31:0] rx_data_reg;
  logic [5:0] rx_cnt;
  logic [5:0] rx_len;
  logic [5:0] next_rx_cnt;
  logic [31:0] next_rx_word;
  logic rx_busy;
  logic rx_take;
  logic rx_done;
  logic rx_hold_full;
  logic rx_move;
  logic rx_read;
  logic rx_ready_flag;
  logic rx_overrun_flag;
  logic rx_sync_error_flag;

  assign rx_len = bsp_pkg::bsp_elem_len(cfg.rx_len_code);
  assign rx_take = rx_fall && (rx_busy || rx_fs_int);
  assign next_rx_cnt = rx_busy ? rx_cnt + 6'h01 : 6'h01;
  assign next_rx_word = rx_busy ? {rx_shift_reg[30:0], pin_sync[4]} : {31'h0, pin_sync[4]};
  assign rx_done = rx_take && (next_rx_cnt == rx_len);
  assign rx_move = rx_hold_full && !rx_ready_flag;
  assign rx_read = (reg_rd && (reg_addr == bsp_pkg::OFS_RX_DATA)) || dma_rd;

  // Shift in on the falling bit clock, counting against element length
  always_ff @(posedge sys_clk) begin
    if (reset || !rx_section_reset_n) begin
      rx_busy <= 1'b0;
      rx_cnt <= 6'h00;
      rx_shift_reg <= 32'h0000_0000;
    end else if (rx_take) begin
      rx_shift_reg <= next_rx_word;
      rx_busy <= !rx_done;
      rx_cnt <= rx_done ? 6'h00 : next_rx_cnt;
    end
  end

  // Holding buffer and readable register; the move waits for the ready flag to clear
  always_ff @(posedge sys_clk) begin
    if (reset || !rx_section_reset_n) begin
      rx_hold_full <= 1'b0;
      rx_holding_buffer <= 32'h0000_0000;
      rx_data_reg <= 32'h0000_0000;
    end else begin
      if (rx_move) begin
        rx_data_reg <= rx_holding_buffer;
      end
      if (rx_done && (!rx_hold_full || rx_move)) begin
        rx_holding_buffer <= next_rx_word;
        rx_hold_full <= 1'b1;
      end else if (rx_move) begin
        rx_hold_full <= 1'b0;
      end
    end
  end

  // Receive status; a set in the clearing cycle wins
  always_ff @(posedge sys_clk) begin
    if (reset || !rx_section_reset_n) begin
      rx_ready_flag <= 1'b0;
      rx_overrun_flag <= 1'b0;
      rx_sync_error_flag <= 1'b0;
    end else begin
      if (rx_move) begin
        rx_ready_flag <= 1'b1;
      end else if (rx_read) begin
        rx_ready_flag <= 1'b0;
      end
      if (rx_done && rx_hold_full && !rx_move) begin
        rx_overrun_flag <= 1'b1;
      end else if (rx_read) begin
        rx_overrun_flag <= 1'b0;
      end
      if (rx_fall && rx_busy && rx_fs_int && !rx_done) begin
        rx_sync_error_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  bsp_pkg::bsp_tx_state_t tx_state;
  logic [31:0] tx_data_reg;
  logic [31:0] tx_shift_reg;
  logic [5:0] tx_cnt;
  logic [5:0] tx_len;
  logic tx_full;
  logic tx_sr_loaded;
  logic tx_last;
  logic tx_load;
  logic tx_start;
  logic tx_write;
  logic tx_rst_prev;
  logic tx_ready_flag;
  logic tx_underrun_flag;
  logic tx_sync_error_flag;

  assign tx_len = bsp_pkg::bsp_elem_len(cfg.tx_len_code);
  assign tx_write = (reg_wr && (reg_addr == bsp_pkg::OFS_TX_DATA)) || dma_wr;
  assign tx_last = tx_rise && (tx_state == bsp_pkg::BSP_TX_SHIFT) &&
                   (tx_cnt == tx_len - 6'h01);
  assign tx_load = tx_full && (!tx_sr_loaded || tx_last);
  assign tx_start = tx_rise && tx_fs_int && tx_sr_loaded &&
                    (tx_state == bsp_pkg::BSP_TX_ARMED);

  // Sequencer: first sync only arms, later syncs start an element
  always_ff @(posedge sys_clk) begin
    if (reset || !tx_section_reset_n) begin
      tx_state <= bsp_pkg::BSP_TX_IDLE;
    end else begin
      unique case (tx_state)
        bsp_pkg::BSP_TX_IDLE: begin
          if (tx_rise && tx_fs_int) begin
            tx_state <= bsp_pkg::BSP_TX_ARMED;
          end
        end
        bsp_pkg::BSP_TX_ARMED: begin
          if (tx_start) begin
            tx_state <= bsp_pkg::BSP_TX_SHIFT;
          end
        end
        bsp_pkg::BSP_TX_SHIFT: begin
          if (tx_last) begin
            tx_state <= bsp_pkg::BSP_TX_ARMED;
          end
        end
        default: tx_state <= bsp_pkg::BSP_TX_IDLE;
      endcase
    end
  end

  // Shift register: MSB goes out first, shifted on rising bit clock
  always_ff @(posedge sys_clk) begin
    if (reset || !tx_section_reset_n) begin
      tx_shift_reg <= 32'h0000_0000;
      tx_sr_loaded <= 1'b0;
      tx_cnt <= 6'h00;
    end else begin
      if (tx_load) begin
        tx_shift_reg <= bsp_pkg::bsp_left_align(tx_data_reg, tx_len);
        tx_sr_loaded <= 1'b1;
        tx_cnt <= 6'h00;
      end else if (tx_last) begin
        tx_sr_loaded <= 1'b0;
        tx_cnt <= 6'h00;
      end else if (tx_rise && (tx_state == bsp_pkg::BSP_TX_SHIFT)) begin
        tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
        tx_cnt <= tx_cnt + 6'h01;
      end
    end
  end

  // Data register; processor wins if both masters write together
  always_ff @(posedge sys_clk) begin
    if (reset || !tx_section_reset_n) begin
      tx_data_reg <= 32'h0000_0000;
      tx_full <= 1'b0;
    end else if (tx_write) begin
      tx_data_reg <= reg_wr ? reg_wdata : dma_wdata;
      tx_full <= 1'b1;
    end else if (tx_load) begin
      tx_full <= 1'b0;
    end
  end

  // Last run bit, so the release from section reset is seen once
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_rst_prev <= 1'b0;
    end else begin
      tx_rst_prev <= tx_section_reset_n;
    end
  end

  // Transmit status; set wins over the clearing write
  always_ff @(posedge sys_clk) begin
    if (reset || !tx_section_reset_n) begin
      tx_ready_flag <= 1'b0;
      tx_underrun_flag <= 1'b0;
      tx_sync_error_flag <= 1'b0;
    end else begin
      if (!tx_rst_prev || tx_load) begin
        tx_ready_flag <= 1'b1;
      end else if (tx_write) begin
        tx_ready_flag <= 1'b0;
      end
      if (tx_last && !tx_full) begin
        tx_underrun_flag <= 1'b1;
      end else if (tx_write) begin
        tx_underrun_flag <= 1'b0;
      end
      if (tx_rise && tx_fs_int && (tx_state == bsp_pkg::BSP_TX_SHIFT) && !tx_last) begin
        tx_sync_error_flag <= 1'b1;
      end
    end
  end

  // Output stays high impedance unless the transmitter runs
  assign serial_out = tx_shift_reg[31];
  assign serial_out_oe = tx_section_reset_n && !reset;
  assign rx_event = rx_ready_flag;
  assign tx_event = tx_ready_flag;

  // ----------------------------------------
  // Read ports
  // ----------------------------------------
  logic [31:0] ctl_word;

  always_comb begin
    ctl_word = 32'h0000_0000;
    ctl_word[bsp_pkg::CTL_RX_RST] = rx_section_reset_n;
    ctl_word[bsp_pkg::CTL_RX_RDY] = rx_ready_flag;
    ctl_word[bsp_pkg::CTL_RX_OVR] = rx_overrun_flag;
    ctl_word[bsp_pkg::CTL_RX_SERR] = rx_sync_error_flag;
    ctl_word[bsp_pkg::CTL_TX_RST] = tx_section_reset_n;
    ctl_word[bsp_pkg::CTL_TX_RDY] = tx_ready_flag;
    ctl_word[bsp_pkg::CTL_TX_UND] = tx_underrun_flag;
    ctl_word[bsp_pkg::CTL_TX_SERR] = tx_sync_error_flag;
    ctl_word[bsp_pkg::CTL_GEN_RST] = rate_gen_reset_n;
    ctl_word[bsp_pkg::CTL_FRM_RST] = frame_gen_reset_n;
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        bsp_pkg::OFS_RX_DATA: reg_rdata <= rx_data_reg;
        bsp_pkg::OFS_TX_DATA: reg_rdata <= tx_data_reg;
        bsp_pkg::OFS_CONTROL: reg_rdata <= ctl_word;
        bsp_pkg::OFS_PIN_CFG: reg_rdata <= {10'h000, pin_sync, 5'h00, pin_cfg};
        bsp_pkg::OFS_CONFIG: reg_rdata <= {10'h000, cfg};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // DMA sees only the data registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dma_rdata <= 32'h0000_0000;
    end else begin
      dma_rdata <= dma_rd ? rx_data_reg : 32'h0000_0000;
    end
  end

endmodule

// ---- tb/bsp_core_monitor.sv ----
// Purpose: Port-level checks of bsp_core
// Assumes: One clock domain, sys_clk
// Notes: Bound into every bsp_core instance
module bsp_core_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic dma_wr,
  input wire logic dma_rd,
  input wire logic [31:0] dma_rdata,
  input wire logic rx_event,
  input wire logic tx_event,
  input wire logic serial_out_oe,
  input wire logic rx_bit_clock_oe,
  input wire logic tx_bit_clock_oe,
  input wire logic rx_frame_sync_oe,
  input wire logic tx_frame_sync_oe,
  input wire logic rx_frame_sync_out,
  input wire logic tx_frame_sync_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic any_oe;
  // Any pin the port may drive
  assign any_oe = serial_out_oe | rx_bit_clock_oe | tx_bit_clock_oe
    | rx_frame_sync_oe | tx_frame_sync_oe;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ----
  // Host steps
  // ----
  sequence rx_read;
    dma_rd || (reg_rd && reg_addr == bsp_pkg::OFS_RX_DATA);
  endsequence
  sequence tx_write;
    dma_wr || (reg_wr && reg_addr == bsp_pkg::OFS_TX_DATA);
  endsequence
  a_pins_released: assert property ($past(reset) |-> !any_oe)
    else $error("pin driven after reset");
  a_syncs_idle: assert property ($past(reset) |-> !rx_frame_sync_out && !tx_frame_sync_out)
    else $error("frame sync active after reset");
  a_flags_cleared: assert property ($past(reset) |-> !rx_event && !tx_event)
    else $error("ready flag set after reset");
  a_rdata_single: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside answer cycle");
  a_dma_single: assert property (!$past(dma_rd) |-> dma_rdata == '0)
    else $error("dma data outside answer cycle");
  // A move in the read cycle sets ready again, so only a read of set data must clear it
  a_rx_read_clear: assert property (rx_read ##0 rx_event |=> !rx_event)
    else $error("rx ready kept after read");
  a_tx_write_clear: assert property (tx_write |=> !tx_event)
    else $error("tx ready kept after write");
  a_oe_needs_write: assert property ($rose(any_oe) |-> $past(reg_wr))
    else $error("pin enabled without a write");
endmodule

bind bsp_core bsp_core_monitor u_mon (.*);

// ---- tb/bsp_codec_model.sv ----
// Purpose: Serial codec on the far side of bsp_core
// Assumes: 16-bit elements in 20-bit frames, one shared 400 ns bit clock
// Notes: Clock stands low and data toggles while run is low
module bsp_codec_model (
  input wire logic run,
  input wire logic [15:0] base,
  input wire logic serial_out,
  output logic bclk,
  output logic fsync,
  output logic sdata,
  output logic [7:0] frame_n,
  output logic [15:0] cap
);
  timeunit 1ns;
  timeprecision 1ns;
  int i;
  logic [15:0] w;
  // ----
  // Frame loop
  // ----
  // Sync leads the first rising edge so both edges of bit 0 see it
  initial begin
    {bclk, fsync, sdata, frame_n, cap} = '0;
    forever begin
      if (run !== 1'b1) begin
        sdata = ~sdata; // Released line shows no stale bit
        #400;
      end else begin
        w = base ^ {frame_n, frame_n};
        fsync = 1'b1;
        #100;
        for (i = 0; i < 20; i++) begin
          sdata = (i < 16) ? w[15 - i] : ~sdata;
          bclk = 1'b1;
          #200;
          bclk = 1'b0;
          #100;
          fsync = 1'b0;
          #100;
          if (i < 16) cap = {cap[14:0], serial_out}; // Sampled just before next rise
        end
        frame_n = frame_n + 8'h01;
      end
    end
  end
endmodule

// ---- tb/bsp_core_bench.sv ----
// Purpose: Self-checking bench for bsp_core
// Assumes: Codec model clocks both sections from outside
// Notes: Element length stays at its 16-bit reset value
module bsp_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, reset, reg_wr, reg_rd, dma_wr, dma_rd, run;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, dma_wdata, reg_rdata, dma_rdata, w0, w1, g;
  logic [15:0] base, cap;
  logic [7:0] frame_n;
  logic rx_event, tx_event, so, so_oe, ck, fs, sd;
  logic rco, rce, tco, tce, rfo, rfe, tfo, tfe;
  int n_mismatch, checks, k;
  bsp_core u_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dma_wr(dma_wr), .dma_wdata(dma_wdata), .dma_rd(dma_rd), .dma_rdata(dma_rdata),
    .rx_event(rx_event), .tx_event(tx_event), .serial_in(sd), .serial_out(so),
    .serial_out_oe(so_oe), .ext_source_clock(1'b0),
    .rx_bit_clock_in(rce ? rco : ck), .rx_bit_clock_out(rco), .rx_bit_clock_oe(rce),
    .tx_bit_clock_in(tce ? tco : ck), .tx_bit_clock_out(tco), .tx_bit_clock_oe(tce),
    .rx_frame_sync_in(rfe ? rfo : fs), .rx_frame_sync_out(rfo), .rx_frame_sync_oe(rfe),
    .tx_frame_sync_in(tfe ? tfo : fs), .tx_frame_sync_out(tfo), .tx_frame_sync_oe(tfe));
  bsp_codec_model u_codec (.run(run), .base(base), .serial_out(so_oe ? so : ~so),
    .bclk(ck), .fsync(fs), .sdata(sd), .frame_n(frame_n), .cap(cap));
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] rx_word(input logic [7:0] n);
    return {16'h0000, base ^ {n, n}}; // Right justified, zero filled
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d; // Whole words only
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  // Flags move on bit clock events, so allow a few bit times
  task automatic wait_ev(input bit tx);
    for (k = 0; k < 40 && (tx ? tx_event : rx_event) !== 1'b1; k++) @(posedge sys_clk);
    #1 chk({31'h0, tx ? tx_event : rx_event}, 32'h1);
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // Clock, watchdog, tests
  // ----
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // About 40 us of traffic expected
  initial begin
    #300us;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {reg_wr, reg_rd, dma_wr, dma_rd, run, reg_addr, reg_wdata, dma_wdata} = '0;
    reset = 1'b1;
    k = $urandom(97796);
    {w0, w1, g} = {$urandom, $urandom, $urandom};
    base = 16'($urandom);
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rd(bsp_pkg::OFS_CONTROL, '1, 32'h0);
    rd(bsp_pkg::OFS_CONFIG, 32'h003FFFFF, 32'h0007C052);
    wr(5'h14, $urandom);
    rd(5'h14, '1, 32'h0);
    wr(bsp_pkg::OFS_PIN_CFG, {21'h0, g[3:0], 7'h0F});
    chk({24'h0, tfo, rfo, tco, rco, tfe, rfe, tce, rce}, {24'h0, g[3:0], 4'hF});
    rd(bsp_pkg::OFS_PIN_CFG, 32'h7FF, {21'h0, g[3:0], 7'h0F});
    wr(bsp_pkg::OFS_PIN_CFG, 32'h3F);
    wr(bsp_pkg::OFS_CONTROL, 32'h00800000); // Generator stays off
    chk({27'h0, rco, tco, rfo, tfo, so_oe}, 32'h6);
    wr(bsp_pkg::OFS_CONTROL, 32'h00C00000); // No section uses it yet
    k = 0;
    repeat (40) begin
      g[0] = tco;
      @(posedge sys_clk);
      #1 chk({30'h0, rfo, tfo}, 32'h3);
      k += int'(g[0] !== tco);
    end
    chk(32'(k != 0), 32'h1);
    wr(bsp_pkg::OFS_PIN_CFG, 32'h0);
    wr(bsp_pkg::OFS_CONTROL, 32'h00010001); // Sections on outside clocks
    run <= 1'b1;
    wait_ev(1'b1);
    wr(bsp_pkg::OFS_TX_DATA, w0);
    wait_ev(1'b1);
    @(posedge sys_clk);
    dma_wr <= 1'b1;
    dma_wdata <= w1;
    @(posedge sys_clk);
    dma_wr <= 1'b0;
    wait (frame_n == 8'h02);
    chk({16'h0, cap}, {16'h0, w0[15:0]});
    wait (frame_n == 8'h03);
    chk({16'h0, cap}, {16'h0, w1[15:0]});
    run <= 1'b0;
    wait (frame_n == 8'h04);
    chk({31'h0, so_oe}, 32'h1);
    rd(bsp_pkg::OFS_CONTROL, '1, 32'h00070007);
    rd(bsp_pkg::OFS_RX_DATA, '1, rx_word(8'h00));
    wait_ev(1'b0);
    @(posedge sys_clk);
    dma_rd <= 1'b1;
    @(posedge sys_clk);
    dma_rd <= 1'b0;
    #1 chk(dma_rdata, rx_word(8'h01));
    wr(bsp_pkg::OFS_CONTROL, 32'h0);
    rd(bsp_pkg::OFS_CONTROL, '1, 32'h0);
    chk({29'h0, rx_event, tx_event, so_oe}, 32'h0);
    print_verdict();
  end
endmodule
